/* File: can_tx_pkg.sv */
// Constants, types and helpers shared by the transmit-buffer bookkeeping.
`default_nettype none
package can_tx_pkg;

  localparam int NUM_BUF = 3;

  // Register indices; each register's byte address is four times its index.
  localparam logic [5:0] IDX_TX_FLAGS     = 6'h06;
  localparam logic [5:0] IDX_TX_IRQ_EN    = 6'h07;
  localparam logic [5:0] IDX_TX_ABORT_REQ = 6'h08;
  localparam logic [5:0] IDX_TX_ABORT_ACK = 6'h09;
  localparam logic [5:0] IDX_MODE_CTRL    = 6'h0c;
  localparam logic [5:0] IDX_MODE_STATUS  = 6'h0d;
  localparam logic [5:0] IDX_EVT_STATUS   = 6'h0e;
  localparam logic [5:0] IDX_EVT_MASK     = 6'h0f;

  // Field positions.
  localparam int CTRL_INIT_BIT   = 0;
  localparam int CTRL_LISTEN_BIT = 1;
  localparam int MODE_INIT_ACK   = 0;
  localparam int EVT_SENT_LSB    = 0;
  localparam int EVT_ABORT_LSB   = 3;

  // Values after reset.
  localparam logic [2:0] TX_FLAGS_RESET  = 3'h7;
  localparam logic [2:0] IRQ_EN_RESET    = 3'h0;
  localparam logic [2:0] ABORT_REQ_RESET = 3'h0;
  localparam logic [2:0] ABORT_ACK_RESET = 3'h0;
  localparam logic [1:0] MODE_CTRL_RESET = 2'h0;
  localparam logic [5:0] EVT_RESET       = 6'h00;

  // Bus encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // Register port sequencing states.
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_READ = 1'b1
  } port_state_t;

  // Sticky update: a set arriving with a clear wins.
  function automatic logic [5:0] sticky(input logic [5:0] cur,
                                        input logic [5:0] set,
                                        input logic [5:0] clr);
    return set | (cur & ~clr);
  endfunction : sticky

endpackage : can_tx_pkg
`default_nettype wire

/* File: can_tx_ahb_port.sv */
// AHB-Lite slave front end: writes with no wait, reads with one wait state.
`timescale 1ns/10ps
`default_nettype none
module can_tx_ahb_port (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] rd_data,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             wr_en,
  output logic [5:0]       word_idx,
  output logic [31:0]      wr_data
);

  can_tx_pkg::port_state_t state_reg, state_next;
  logic [5:0]  addr_reg, addr_next;
  logic        wr_pend_reg, wr_pend_next;
  logic        ready_reg, ready_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        take;

  // Only whole-word transfers inside the 256-byte window are taken.
  assign take = hsel && hready && (htrans == can_tx_pkg::HTRANS_NONSEQ)
                && (hsize == can_tx_pkg::HSIZE_WORD)
                && (haddr[31:8] == 24'h000000);

  // Reads sample the registers in the data phase, so a write just before
  // is always seen; the price is one wait state per read.
  always_comb begin
    state_next   = state_reg;
    addr_next    = addr_reg;
    wr_pend_next = 1'b0;
    ready_next   = ready_reg;
    rdata_next   = rdata_reg;
    case (state_reg)
      can_tx_pkg::ST_IDLE: begin
        if (take) begin
          addr_next = haddr[7:2];
          if (hwrite) begin
            wr_pend_next = 1'b1;
          end else begin
            state_next = can_tx_pkg::ST_READ;
            ready_next = 1'b0;
          end
        end
      end
      can_tx_pkg::ST_READ: begin
        rdata_next = rd_data;
        ready_next = 1'b1;
        state_next = can_tx_pkg::ST_IDLE;
      end
      default: begin
        state_next = can_tx_pkg::ST_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  // Port state registers; frozen while the clock enable is low.
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg   <= can_tx_pkg::ST_IDLE;
      addr_reg    <= 6'h00;
      wr_pend_reg <= 1'b0;
      ready_reg   <= 1'b1;
      rdata_reg   <= 32'h00000000;
      hresp       <= 1'b0;
    end else if (clk_en) begin
      state_reg   <= state_next;
      addr_reg    <= addr_next;
      wr_pend_reg <= wr_pend_next;
      ready_reg   <= ready_next;
      rdata_reg   <= rdata_next;
      hresp       <= 1'b0;
    end
  end

  assign hreadyout = ready_reg;
  assign hrdata    = rdata_reg;
  assign wr_en     = wr_pend_reg && clk_en;
  assign word_idx  = addr_reg;
  assign wr_data   = hwdata;

endmodule : can_tx_ahb_port
`default_nettype wire

/* File: can_tx_buffer_flag_abort_ctrl.sv */
// Transmit-buffer empty flags, interrupt enables and abort handling.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module can_tx_buffer_flag_abort_ctrl (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [2:0]  tx_sent,
  input  wire logic [2:0]  tx_in_progress,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic [2:0]       tx_scheduled,
  output logic [2:0]       buffer_access_blocked,
  output logic [2:0]       abort_granted,
  output logic             tx_irq,
  output logic             event_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register port.

  logic        wr_en;
  logic [5:0]  word_idx;
  logic [31:0] wr_data;
  logic [31:0] rd_data;

  // The bus front end presents one write strobe per accepted write.
  can_tx_ahb_port u_port (
    .mclk      (mclk),
    .reset     (reset),
    .clk_en    (clk_en),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .rd_data   (rd_data),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_en     (wr_en),
    .word_idx  (word_idx),
    .wr_data   (wr_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State declarations.

  logic [2:0] flags_reg;
  logic [2:0] flags_next;
  logic [2:0] irq_en_reg;
  logic [2:0] irq_en_next;
  logic [2:0] abort_req_reg;
  logic [2:0] abort_req_next;
  logic [2:0] abort_ack_reg;
  logic [2:0] abort_ack_next;
  logic       init_req_reg;
  logic       init_req_next;
  logic       init_ack_reg;
  logic       init_ack_next;
  logic       listen_reg;
  logic       listen_next;
  logic [5:0] evt_status_reg;
  logic [5:0] evt_status_next;
  logic [5:0] evt_mask_reg;
  logic [5:0] evt_mask_next;

  logic [2:0] tx_sched_reg;
  logic [2:0] tx_sched_next;
  logic [2:0] blocked_reg;
  logic [2:0] blocked_next;
  logic [2:0] granted_reg;
  logic [2:0] granted_next;
  logic       tx_irq_reg;
  logic       tx_irq_next;
  logic       evt_irq_reg;
  logic       evt_irq_next;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and events.

  logic       in_init;
  logic       writable;
  logic       wr_flags;
  logic       wr_irq_en;
  logic       wr_abort_req;
  logic       wr_ctrl;
  logic       wr_evt_status;
  logic       wr_evt_mask;
  logic [2:0] sent_ok;
  logic [2:0] grant;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic [2:0] flag_rise;
  logic [2:0] flag_fall;
  logic [5:0] flag_tmp;
  logic [5:0] ack_tmp;
  logic [5:0] evt_set;

  // Initialization mode holds the registers only when both request and
  // acknowledge are high; writes need both low, so during the handshake
  // the registers neither reset nor accept writes.
  assign in_init  = init_req_reg && init_ack_reg;
  assign writable = !init_req_reg && !init_ack_reg;

  // Write strobes per register.
  assign wr_flags      = wr_en && (word_idx == can_tx_pkg::IDX_TX_FLAGS)
                         && writable;
  assign wr_irq_en     = wr_en && (word_idx == can_tx_pkg::IDX_TX_IRQ_EN)
                         && writable;
  assign wr_abort_req  = wr_en
                         && (word_idx == can_tx_pkg::IDX_TX_ABORT_REQ)
                         && writable;
  assign wr_ctrl       = wr_en && (word_idx == can_tx_pkg::IDX_MODE_CTRL);
  assign wr_evt_status = wr_en && (word_idx == can_tx_pkg::IDX_EVT_STATUS);
  assign wr_evt_mask   = wr_en && (word_idx == can_tx_pkg::IDX_EVT_MASK);

  // A completion only counts for a buffer that is actually scheduled.
  assign sent_ok = tx_sent & ~flags_reg;

  // Abort is granted while the engine is not sending the buffer: either
  // it never started or it dropped the attempt after lost arbitration or
  // an error. A completion in the same cycle wins; the message went out.
  assign grant = abort_req_reg & ~flags_reg & ~tx_in_progress
                 & ~tx_sent;

  // Flags are set by sending or by a granted abort.
  assign flag_set = sent_ok | grant;

  // Clears come from a write of ones and are ignored in listen mode.
  assign flag_clr = wr_flags ? (wr_data[2:0] & {3{!listen_reg}})
                             : 3'h0;

  // Set beats clear in the same cycle.
  assign flag_tmp = can_tx_pkg::sticky({3'h0, flags_reg},
                                       {3'h0, flag_set},
                                       {3'h0, flag_clr});

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer registers.

  // Next values for flags, enables, abort requests and acknowledges.
  always_comb begin
    flags_next     = flags_reg;
    irq_en_next    = irq_en_reg;
    abort_req_next = abort_req_reg;
    abort_ack_next = abort_ack_reg;
    flag_rise      = 3'h0;
    flag_fall      = 3'h0;
    ack_tmp        = 6'h00;
    if (in_init) begin
      flags_next     = can_tx_pkg::TX_FLAGS_RESET;
      irq_en_next    = can_tx_pkg::IRQ_EN_RESET;
      abort_req_next = can_tx_pkg::ABORT_REQ_RESET;
      abort_ack_next = can_tx_pkg::ABORT_ACK_RESET;
    end else begin
      flags_next = flag_tmp[2:0];
      flag_rise  = flags_next & ~flags_reg;
      flag_fall  = flags_reg & ~flags_next;
      if (wr_irq_en) begin
        irq_en_next = wr_data[2:0];
      end
      // Requests only stick on scheduled buffers and software can only
      // add ones; the block alone removes them.
      if (wr_abort_req) begin
        abort_req_next = abort_req_reg
                         | (wr_data[2:0] & ~flags_reg);
      end
      abort_req_next = abort_req_next & ~flag_rise;
      // An acknowledge is raised by the grant and dropped when software
      // schedules the buffer again.
      ack_tmp = can_tx_pkg::sticky({3'h0, abort_ack_reg},
                                   {3'h0, grant},
                                   {3'h0, flag_fall});
      abort_ack_next = ack_tmp[2:0];
    end
  end

  // Transmit buffer state.
  always_ff @(posedge mclk) begin
    if (reset) begin
      flags_reg     <= can_tx_pkg::TX_FLAGS_RESET;
      irq_en_reg    <= can_tx_pkg::IRQ_EN_RESET;
      abort_req_reg <= can_tx_pkg::ABORT_REQ_RESET;
      abort_ack_reg <= can_tx_pkg::ABORT_ACK_RESET;
    end else if (clk_en) begin
      flags_reg     <= flags_next;
      irq_en_reg    <= irq_en_next;
      abort_req_reg <= abort_req_next;
      abort_ack_reg <= abort_ack_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode control.

  // The acknowledge follows the request one cycle later, so software can
  // poll for it before relying on the held registers.
  always_comb begin
    init_req_next = init_req_reg;
    listen_next   = listen_reg;
    init_ack_next = init_req_reg;
    if (wr_ctrl) begin
      init_req_next = wr_data[can_tx_pkg::CTRL_INIT_BIT];
      listen_next   = wr_data[can_tx_pkg::CTRL_LISTEN_BIT];
    end
  end

  // Mode state.
  always_ff @(posedge mclk) begin
    if (reset) begin
      init_req_reg <= can_tx_pkg::MODE_CTRL_RESET[can_tx_pkg::CTRL_INIT_BIT];
      listen_reg   <=
        can_tx_pkg::MODE_CTRL_RESET[can_tx_pkg::CTRL_LISTEN_BIT];
      init_ack_reg <= 1'b0;
    end else if (clk_en) begin
      init_req_reg <= init_req_next;
      listen_reg   <= listen_next;
      init_ack_reg <= init_ack_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event interrupt status and mask.

  assign evt_set = {grant, sent_ok};

  // Sticky event bits, cleared by writing ones; a new event wins.
  always_comb begin
    evt_status_next = can_tx_pkg::sticky(evt_status_reg, evt_set,
                        wr_evt_status ? wr_data[5:0] : 6'h00);
    evt_mask_next   = wr_evt_mask ? wr_data[5:0] : evt_mask_reg;
  end

  // Event state.
  always_ff @(posedge mclk) begin
    if (reset) begin
      evt_status_reg <= can_tx_pkg::EVT_RESET;
      evt_mask_reg   <= can_tx_pkg::EVT_RESET;
    end else if (clk_en) begin
      evt_status_reg <= evt_status_next;
      evt_mask_reg   <= evt_mask_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all taken from flip-flops; all but abort_granted are built from next-state values so
  // they track the registers without an extra cycle of lag. abort_granted registers grant, one cycle after it.

  always_comb begin
    tx_sched_next = ~flags_next & {3{!listen_next}};
    blocked_next  = ~flags_next;
    granted_next  = grant;
    tx_irq_next   = |(flags_next & irq_en_next);
    evt_irq_next  = |(evt_status_next & evt_mask_next);
  end

  // Output registers.
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_sched_reg <= 3'h0;
      blocked_reg  <= 3'h0;
      granted_reg  <= 3'h0;
      tx_irq_reg   <= 1'b0;
      evt_irq_reg  <= 1'b0;
    end else if (clk_en) begin
      tx_sched_reg <= tx_sched_next;
      blocked_reg  <= blocked_next;
      granted_reg  <= granted_next;
      tx_irq_reg   <= tx_irq_next;
      evt_irq_reg  <= evt_irq_next;
    end
  end

  assign tx_scheduled          = tx_sched_reg;
  assign buffer_access_blocked = blocked_reg;
  assign abort_granted         = granted_reg;
  assign tx_irq                = tx_irq_reg;
  assign event_irq             = evt_irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; unmapped words and unused bits read as zero.

  always_comb begin
    rd_data = 32'h00000000;
    case (word_idx)
      can_tx_pkg::IDX_TX_FLAGS: begin
        rd_data[2:0] = flags_reg;
      end
      can_tx_pkg::IDX_TX_IRQ_EN: begin
        rd_data[2:0] = irq_en_reg;
      end
      can_tx_pkg::IDX_TX_ABORT_REQ: begin
        rd_data[2:0] = abort_req_reg;
      end
      can_tx_pkg::IDX_TX_ABORT_ACK: begin
        rd_data[2:0] = abort_ack_reg;
      end
      can_tx_pkg::IDX_MODE_CTRL: begin
        rd_data[can_tx_pkg::CTRL_INIT_BIT]   = init_req_reg;
        rd_data[can_tx_pkg::CTRL_LISTEN_BIT] = listen_reg;
      end
      can_tx_pkg::IDX_MODE_STATUS: begin
        rd_data[can_tx_pkg::MODE_INIT_ACK] = init_ack_reg;
      end
      can_tx_pkg::IDX_EVT_STATUS: begin
        rd_data[5:0] = evt_status_reg;
      end
      can_tx_pkg::IDX_EVT_MASK: begin
        rd_data[5:0] = evt_mask_reg;
      end
      default: begin
        rd_data = 32'h00000000;
      end
    endcase
  end

endmodule : can_tx_buffer_flag_abort_ctrl
`default_nettype wire

/* File: can_tx_engine_model.sv */
// Behavioural model of the transmit engine that serves the queued buffers.
`timescale 1ns/10ps
`default_nettype none
module can_tx_engine_model #(
  parameter int DLY = 100
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [2:0] tx_scheduled,
  input  wire logic [2:0] go,
  output logic      [2:0] tx_sent,
  output logic      [2:0] tx_in_progress
);
  logic [7:0] cnt [3];

  // A queued buffer is sent DLY+1 cycles after it starts while go holds.
  // Dropping go mid-frame stands for lost arbitration: no success pulse.
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 3; i++) begin
      tx_sent[i] <= 1'b0;
      if (reset || !go[i] || !tx_scheduled[i] || tx_sent[i]) begin
        tx_in_progress[i] <= 1'b0;
        cnt[i]            <= 8'h00;
      end else if (!tx_in_progress[i]) begin
        tx_in_progress[i] <= 1'b1;
        cnt[i]            <= 8'(DLY);
      end else if (cnt[i] == 8'h00) begin
        tx_sent[i]        <= 1'b1;
        tx_in_progress[i] <= 1'b0;
      end else begin
        cnt[i] <= cnt[i] - 8'h01;
      end
    end
  end
endmodule : can_tx_engine_model
`default_nettype wire

/* File: can_tx_buffer_flag_abort_ctrl_monitor.sv */
// Port-level checker of the transmit-buffer bookkeeping.
`timescale 1ns/10ps
`default_nettype none
module can_tx_buffer_flag_abort_ctrl_monitor (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [2:0]  tx_sent,
  input wire logic [2:0]  tx_in_progress,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [2:0]  tx_scheduled,
  input wire logic [2:0]  buffer_access_blocked,
  input wire logic [2:0]  abort_granted,
  input wire logic        tx_irq,
  input wire logic        event_irq
);
  logic take;

  // Every property samples on mclk and rests while reset is high.
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // A transfer is taken only for a selected word access inside the map.
  assign take = hsel && hready && clk_en && haddr[31:8] == 24'h0 &&
                htrans == can_tx_pkg::HTRANS_NONSEQ &&
                hsize == can_tx_pkg::HSIZE_WORD;

  ////////////////////////////////////////////////////////////////////////
  a_write_no_wait: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase was stretched");
  a_read_one_wait: assert property (take && !hwrite |=>
    !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  a_resp_always_okay: assert property (!hresp)
    else $error("register bus answered with an error");
  a_sent_empties: assert property (clk_en &&
    |(tx_sent & buffer_access_blocked) |=>
    (buffer_access_blocked & $past(tx_sent)) == 3'h0)
    else $error("sent buffer not flagged empty");
  a_grant_empties: assert property (|abort_granted |->
    (abort_granted & buffer_access_blocked) == 3'h0)
    else $error("aborted buffer not flagged empty");
  a_grant_when_idle: assert property (|abort_granted |->
    (abort_granted & ($past(tx_in_progress) | $past(tx_sent))) == 3'h0)
    else $error("abort granted during transmission");
  a_grant_was_queued: assert property (|abort_granted |->
    ($past(buffer_access_blocked) & abort_granted) == abort_granted)
    else $error("abort granted on an empty buffer");
  a_grant_one_pulse: assert property (|abort_granted |=>
    (abort_granted & $past(abort_granted)) == 3'h0)
    else $error("abort grant pulse too long");
  a_queue_needs_full: assert property
    ((tx_scheduled & ~buffer_access_blocked) == 3'h0)
    else $error("empty buffer offered for transmission");
  a_irq_needs_flag: assert property
    (tx_irq |-> buffer_access_blocked != 3'h7)
    else $error("transmit interrupt with no empty buffer");

  // Main traffic that the bench is expected to reach.
  c_grant: cover property (|abort_granted);
  c_sent: cover property (|tx_sent);
  c_read: cover property (take && !hwrite);
endmodule : can_tx_buffer_flag_abort_ctrl_monitor

bind can_tx_buffer_flag_abort_ctrl can_tx_buffer_flag_abort_ctrl_monitor
  can_tx_buffer_flag_abort_ctrl_monitor_inst (
  .mclk(mclk), .reset(reset), .clk_en(clk_en), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .tx_sent(tx_sent),
  .tx_in_progress(tx_in_progress), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .tx_scheduled(tx_scheduled),
  .buffer_access_blocked(buffer_access_blocked),
  .abort_granted(abort_granted), .tx_irq(tx_irq), .event_irq(event_irq));
`default_nettype wire

/* File: can_tx_buffer_flag_abort_ctrl_tb.sv */
// Self-checking bench for the transmit-buffer bookkeeping.
`timescale 1ns/10ps
`default_nettype none
module can_tx_buffer_flag_abort_ctrl_tb;
  typedef struct packed {
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] ra;
    logic [7:0] ex;
  } row_t;
  logic        mclk   = 1'b0;
  logic        reset  = 1'b1;
  logic        hsel   = 1'b1;
  logic [31:0] haddr  = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize  = can_tx_pkg::HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  go     = 3'h5;
  logic        clk_en = 1'b1;
  logic        hready, tx_irq, event_irq;
  logic [31:0] hrdata, q;
  logic [2:0]  tx_sent, tx_in_progress, tx_scheduled, blocked, granted;
  int          failures = 0, comparisons = 0, n;
  // Write one word, then read back the named word; the first four rows write to an unmapped word.
  row_t rows [10] = '{
    '{8'h00, 8'hff, 8'h18, 8'h07}, '{8'h00, 8'hff, 8'h1c, 8'h00},
    '{8'h00, 8'hff, 8'h20, 8'h00}, '{8'h00, 8'hff, 8'h24, 8'h00},
    '{8'h1c, 8'h05, 8'h1c, 8'h05}, '{8'h18, 8'h00, 8'h18, 8'h07},
    '{8'h20, 8'h07, 8'h20, 8'h00}, '{8'h24, 8'h07, 8'h24, 8'h00},
    '{8'h40, 8'hff, 8'h40, 8'h00}, '{8'h1c, 8'h01, 8'h1c, 8'h01}};

  can_tx_buffer_flag_abort_ctrl can_tx_buffer_flag_abort_ctrl_inst (
    .mclk(mclk), .reset(reset), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .tx_sent(tx_sent),
    .tx_in_progress(tx_in_progress), .hreadyout(hready), .hresp(),
    .hrdata(hrdata), .tx_scheduled(tx_scheduled),
    .buffer_access_blocked(blocked), .abort_granted(granted),
    .tx_irq(tx_irq), .event_irq(event_irq));
  can_tx_engine_model can_tx_engine_model_inst (
    .mclk(mclk), .reset(reset), .tx_scheduled(tx_scheduled), .go(go),
    .tx_sent(tx_sent), .tx_in_progress(tx_in_progress));

  // The 40 MHz module clock.
  always #12.5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////
  // One single word transfer; entered just after a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= can_tx_pkg::HTRANS_NONSEQ;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    q = hrdata;
  endtask : bus

  task automatic check(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, e);
    bus(1'b0, a, 8'h00);
    check($sformatf("register %h", a), q, {24'h0, e});
  endtask : rd

  // The grant pulse lasts one cycle, so it is looked for at every edge.
  task automatic wait_grant(input int i, output int k);
    for (k = 0; k < 40; k++) begin
      @(posedge mclk);
      if (granted[i] === 1'b1) break;
    end
  endtask : wait_grant

  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////
  // Main sequence: table rows first, then the awkward cases.
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, rows[i].ex);
    end
    $display("test done: register table");
    wr(8'h18, 8'h01);
    rd(8'h18, 8'h06);
    check("tx_irq", tx_irq, 1'b0);
    check("tx_scheduled", tx_scheduled, 3'h1);
    check("blocked", blocked, 3'h1);
    for (n = 0; n < 300 && blocked[0] !== 1'b0; n++) @(posedge mclk);
    rd(8'h18, 8'h07);
    check("tx_irq", tx_irq, 1'b1);
    rd(8'h38, 8'h01);
    check("event_irq", event_irq, 1'b0);
    wr(8'h3c, 8'h3f);
    rd(8'h3c, 8'h3f);
    check("event_irq", event_irq, 1'b1);
    wr(8'h38, 8'h01);
    rd(8'h38, 8'h00);
    check("event_irq", event_irq, 1'b0);
    $display("test done: send and interrupt");
    wr(8'h18, 8'h02);
    wr(8'h20, 8'h02);
    wait_grant(1, n);
    check("idle grant", n < 40, 1'b1);
    rd(8'h18, 8'h07);
    rd(8'h24, 8'h02);
    rd(8'h20, 8'h00);
    rd(8'h38, 8'h10);
    wr(8'h18, 8'h02);
    rd(8'h24, 8'h00);
    $display("test done: abort of idle buffer");
    wr(8'h18, 8'h04);
    wr(8'h20, 8'h04);
    wr(8'h20, 8'h00);
    rd(8'h20, 8'h04);
    wait_grant(2, n);
    check("busy grant", n, 40);
    check("in progress", tx_in_progress[2], 1'b1);
    go <= 3'h1;
    wait_grant(2, n);
    check("failed grant", n < 40, 1'b1);
    rd(8'h24, 8'h04);
    rd(8'h18, 8'h05);
    $display("test done: abort of busy buffer");
    wr(8'h30, 8'h02);
    wr(8'h18, 8'h04);
    rd(8'h18, 8'h05);
    check("tx_scheduled", tx_scheduled, 3'h0);
    wr(8'h30, 8'h00);
    $display("test done: listen mode");
    wr(8'h1c, 8'h07);
    wr(8'h30, 8'h01);
    rd(8'h34, 8'h01);
    rd(8'h18, 8'h07);
    rd(8'h1c, 8'h00);
    wr(8'h1c, 8'h07);
    rd(8'h1c, 8'h00);
    check("tx_irq", tx_irq, 1'b0);
    wr(8'h30, 8'h00);
    rd(8'h34, 8'h00);
    $display("test done: initialization mode");
    // A reset in mid-run must drop the pending event interrupt as well.
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    check("event_irq", event_irq, 1'b0);
    check("hready", hready, 1'b1);
    rd(8'h38, 8'h00);
    rd(8'h3c, 8'h00);
    rd(8'h18, 8'h07);
    $display("test done: reset");
    // A write offered while the clock enable is low must be lost.
    clk_en <= 1'b0;
    wr(8'h1c, 8'h07);
    clk_en <= 1'b1;
    rd(8'h1c, 8'h00);
    $display("test done: clock enable");
    end_sim();
  end

  // The run needs well under 1000 cycles; 5000 means a hang.
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    end_sim();
  end
endmodule : can_tx_buffer_flag_abort_ctrl_tb
`default_nettype wire
